// *** core/spd_pkg.sv ***
package spd_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_SYNC_SETUP = 8'h00;
	localparam logic [7:0] ADDR_CLK_TEST   = 8'h04;
	localparam logic [7:0] ADDR_MODE       = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0c;

	// Field positions
	localparam int SYNC_EN_BIT  = 0;
	localparam int DELAY_LSB    = 1;
	localparam int DELAY_W      = 3;
	localparam int POL_BIT      = 4;
	localparam int CLK_TEST_BIT = 7;
	localparam int MODE2_BIT    = 0;
	localparam int ST_SYNC_BIT  = 0;
	localparam int ST_TSYNC_BIT = 1;
	localparam int ST_CONV_BIT  = 2;

	// Values after reset
	localparam logic                 SYNC_EN_RST  = 1'b0;
	localparam logic [DELAY_W-1:0]   DELAY_RST    = 3'h0;
	localparam logic                 POL_RST      = 1'b0;
	localparam logic                 CLK_TEST_RST = 1'b0;
	localparam logic                 MODE2_RST    = 1'b0;

	// Converter clock period in master clocks
	localparam logic [1:0] CONV_DIV_NORMAL = 2'h2;
	localparam logic [1:0] CONV_DIV_MODE2  = 2'h3;
endpackage

// *** core/spd_sync_if.sv ***
`timescale 1ns/1ps
interface spd_sync_if;
	logic       sync_level;
	logic       enable;
	logic       polarity;
	logic [2:0] delay;
	logic       edge_seen;
	logic       pulse;
	logic       timing_sync;

	modport ctrl (
		output sync_level,
		output enable,
		output polarity,
		output delay,
		input  edge_seen,
		input  pulse,
		input  timing_sync
	);
	modport det (
		input  sync_level,
		input  enable,
		input  polarity,
		input  delay,
		output edge_seen,
		output pulse,
		output timing_sync
	);
endinterface // spd_sync_if

// *** core/spd_sync_edge.sv ***
`timescale 1ns/1ps
module spd_sync_edge (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Sync path
	spd_sync_if.det   sif
);
	logic       prev;
	logic [6:0] hist;
	logic [7:0] taps;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prev <= 1'b0;
		end else begin
			prev <= sif.sync_level;
		end
	end

	assign sif.edge_seen = sif.enable &&
		(sif.polarity ? (sif.sync_level && !prev)
		              : (!sif.sync_level && prev));

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hist <= 7'h00;
		end else begin
			hist <= {hist[5:0], sif.edge_seen};
		end
	end

	assign taps = {hist, sif.edge_seen};
	assign sif.pulse = sif.enable && taps[sif.delay];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sif.timing_sync <= 1'b0;
		end else if (sif.enable) begin
			sif.timing_sync <= sif.pulse;
		end else begin
			sif.timing_sync <= sif.sync_level;
		end
	end

	property p_forward;
		@(posedge core_clk) disable iff (srst)
		!sif.enable |=> sif.timing_sync == $past(sif.sync_level);
	endproperty
	a_forward: assert property (p_forward)
		else $error("raw sync not forwarded");

	property p_generated;
		@(posedge core_clk) disable iff (srst)
		sif.enable |=> sif.timing_sync == $past(sif.pulse);
	endproperty
	a_generated: assert property (p_generated)
		else $error("internal pulse not sent to timing");

	property p_ignore;
		@(posedge core_clk) disable iff (srst)
		!sif.enable |-> !sif.pulse && !sif.edge_seen;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("pulse while detection disabled");

	property p_polarity;
		@(posedge core_clk) disable iff (srst)
		sif.pulse && sif.delay == 3'h0 |->
			(sif.polarity ? $rose(sif.sync_level) : $fell(sif.sync_level));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("pulse on wrong edge");

	genvar d;
	generate
		for (d = 0; d < 8; d++) begin : g_dly
			localparam int D = d;
			sequence s_armed;
				sif.edge_seen && sif.delay == D;
			endsequence
			property p_delay;
				@(posedge core_clk) disable iff (srst)
				s_armed |-> ##D (sif.pulse || !sif.enable || sif.delay != D);
			endproperty
			a_delay: assert property (p_delay)
				else $error("pulse delay mismatch");
		end
	endgenerate
endmodule // spd_sync_edge

// *** core/spd_timing_front.sv ***
// Behaviour
// - Detection off: raw sync input goes straight to timing.
// - Detection on: a generated pulse from a sync edge goes to timing.
// - Generated pulse lags the detected edge by exactly the delay field.
// - Detection off: delay and polarity fields have no effect.
// - Polarity 0 detects falling edges, 1 detects rising edges.
// - Test select clear: nibble outputs carry converted sample data.
// - Test select set: bit3 pulse, bit2 video clock, bit1 converter clock.
// - Converter clock is two master clocks, three in second mode.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module spd_timing_front (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Sync pin
	input  wire logic        video_sample_sync_input,
	// Timing controller side
	input  wire logic        video_sample_clk,
	input  wire logic        reset_sample_clk,
	output logic             timing_sync,
	output logic             converter_clk,
	// Data path
	input  wire logic [3:0]  sample_nibble,
	output logic      [3:0]  nibble_output
);
	logic       sync_edge_detect_enable;
	logic [2:0] sync_pulse_delay;
	logic       sync_edge_polarity;
	logic       clock_test_select;
	logic       second_mode;
	logic [2:0] sync_pipe;
	logic       sync_level;
	logic [1:0] div_cnt;
	logic [1:0] div_len;
	logic       wr_en;
	logic       mode_wr;

	spd_sync_if sif ();

	function automatic logic addr_known(input logic [7:0] a);
		return a == spd_pkg::ADDR_SYNC_SETUP || a == spd_pkg::ADDR_CLK_TEST ||
			a == spd_pkg::ADDR_MODE || a == spd_pkg::ADDR_STATUS;
	endfunction

	// Zero wait states: every access completes in one access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_known(paddr);
	assign wr_en   = psel && penable && pwrite && addr_known(paddr);
	assign mode_wr = wr_en && paddr == spd_pkg::ADDR_MODE;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_edge_detect_enable <= spd_pkg::SYNC_EN_RST;
			sync_pulse_delay        <= spd_pkg::DELAY_RST;
			sync_edge_polarity      <= spd_pkg::POL_RST;
		end else if (wr_en && paddr == spd_pkg::ADDR_SYNC_SETUP) begin
			sync_edge_detect_enable <= pwdata[spd_pkg::SYNC_EN_BIT];
			sync_pulse_delay        <=
				pwdata[spd_pkg::DELAY_LSB +: spd_pkg::DELAY_W];
			sync_edge_polarity      <= pwdata[spd_pkg::POL_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			clock_test_select <= spd_pkg::CLK_TEST_RST;
		end else if (wr_en && paddr == spd_pkg::ADDR_CLK_TEST) begin
			clock_test_select <= pwdata[spd_pkg::CLK_TEST_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			second_mode <= spd_pkg::MODE2_RST;
		end else if (mode_wr) begin
			second_mode <= pwdata[spd_pkg::MODE2_BIT];
		end
	end

	// Read data latched in setup so it is steady through access
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				spd_pkg::ADDR_SYNC_SETUP: begin
					prdata[spd_pkg::SYNC_EN_BIT] <= sync_edge_detect_enable;
					prdata[spd_pkg::DELAY_LSB +: spd_pkg::DELAY_W] <=
						sync_pulse_delay;
					prdata[spd_pkg::POL_BIT] <= sync_edge_polarity;
				end
				spd_pkg::ADDR_CLK_TEST: begin
					prdata[spd_pkg::CLK_TEST_BIT] <= clock_test_select;
				end
				spd_pkg::ADDR_MODE: begin
					prdata[spd_pkg::MODE2_BIT] <= second_mode;
				end
				spd_pkg::ADDR_STATUS: begin
					prdata[spd_pkg::ST_SYNC_BIT]  <= sync_level;
					prdata[spd_pkg::ST_TSYNC_BIT] <= sif.timing_sync;
					prdata[spd_pkg::ST_CONV_BIT]  <= converter_clk;
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Pin synchroniser; a change needs two agreeing late stages
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_pipe <= 3'h0;
		end else begin
			sync_pipe <= {sync_pipe[1:0], video_sample_sync_input};
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_level <= 1'b0;
		end else if (sync_pipe[1] == sync_pipe[2]) begin
			sync_level <= sync_pipe[2];
		end
	end

	assign sif.sync_level = sync_level;
	assign sif.enable     = sync_edge_detect_enable;
	assign sif.polarity   = sync_edge_polarity;
	assign sif.delay      = sync_pulse_delay;

	spd_sync_edge u_edge (
		.core_clk (core_clk),
		.srst     (srst),
		.sif      (sif)
	);

	assign timing_sync = sif.timing_sync;

	assign div_len = second_mode ? spd_pkg::CONV_DIV_MODE2
	                             : spd_pkg::CONV_DIV_NORMAL;

	// Wrap at or past the end: after a mode change the count never runs past the end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_cnt <= 2'h0;
		end else if (div_cnt >= div_len - 2'h1) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			converter_clk <= 1'b0;
		end else begin
			converter_clk <= (div_cnt == 2'h0);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			nibble_output <= 4'h0;
		end else if (clock_test_select) begin
			nibble_output <= {sif.pulse, video_sample_clk,
				converter_clk, reset_sample_clk};
		end else begin
			nibble_output <= sample_nibble;
		end
	end

	property p_data_out;
		@(posedge core_clk) disable iff (srst)
		!clock_test_select |=> nibble_output == $past(sample_nibble);
	endproperty
	a_data_out: assert property (p_data_out)
		else $error("sample data not on outputs");

	property p_test_out;
		@(posedge core_clk) disable iff (srst)
		clock_test_select |=> nibble_output[3:1] ==
			$past({sif.pulse, video_sample_clk, converter_clk});
	endproperty
	a_test_out: assert property (p_test_out)
		else $error("timing signals not on outputs");

	property p_rst_clk_out;
		@(posedge core_clk) disable iff (srst)
		clock_test_select |=> nibble_output[0] == $past(reset_sample_clk);
	endproperty
	a_rst_clk_out: assert property (p_rst_clk_out)
		else $error("reset sample clock not on bit 0");

	sequence s_normal_hi;
		$rose(converter_clk) && !second_mode ##1 !second_mode;
	endsequence
	property p_conv2;
		@(posedge core_clk) disable iff (srst)
		s_normal_hi |-> !converter_clk ##1 converter_clk;
	endproperty
	a_conv2: assert property (p_conv2)
		else $error("converter clock not two master clocks");

	sequence s_mode2_hi;
		$rose(converter_clk) && second_mode ##1 second_mode [*2];
	endsequence
	property p_conv3;
		@(posedge core_clk) disable iff (srst)
		s_mode2_hi |-> ($past(converter_clk, 2) && !$past(converter_clk)
			&& !converter_clk) ##1 converter_clk;
	endproperty
	a_conv3: assert property (p_conv3)
		else $error("converter clock not three master clocks");

	property p_setup_wr;
		@(posedge core_clk) disable iff (srst)
		wr_en && paddr == spd_pkg::ADDR_SYNC_SETUP |=>
			sync_edge_detect_enable ==
				$past(pwdata[spd_pkg::SYNC_EN_BIT]) &&
			sync_pulse_delay ==
				$past(pwdata[spd_pkg::DELAY_LSB +: spd_pkg::DELAY_W]) &&
			sync_edge_polarity == $past(pwdata[spd_pkg::POL_BIT]);
	endproperty
	a_setup_wr: assert property (p_setup_wr)
		else $error("sync setup write lost");

	property p_test_wr;
		@(posedge core_clk) disable iff (srst)
		wr_en && paddr == spd_pkg::ADDR_CLK_TEST |=>
			clock_test_select == $past(pwdata[spd_pkg::CLK_TEST_BIT]);
	endproperty
	a_test_wr: assert property (p_test_wr)
		else $error("clock test write lost");

	property p_mode_wr;
		@(posedge core_clk) disable iff (srst)
		mode_wr |=> second_mode == $past(pwdata[spd_pkg::MODE2_BIT]);
	endproperty
	a_mode_wr: assert property (p_mode_wr)
		else $error("mode write lost");

	// Unmapped writes must not disturb any control bit
	property p_regs_keep;
		@(posedge core_clk) disable iff (srst)
		!wr_en |=> $stable({sync_edge_detect_enable, sync_pulse_delay,
			sync_edge_polarity, clock_test_select, second_mode});
	endproperty
	a_regs_keep: assert property (p_regs_keep)
		else $error("control bits moved without a write");

	// Read data follows the register picked in setup
	property p_rd_setup;
		@(posedge core_clk) disable iff (srst)
		psel && !penable && paddr == spd_pkg::ADDR_SYNC_SETUP |=>
			prdata == {27'h0, $past(sync_edge_polarity),
			$past(sync_pulse_delay), $past(sync_edge_detect_enable)};
	endproperty
	a_rd_setup: assert property (p_rd_setup)
		else $error("sync setup read wrong");

	property p_rd_test;
		@(posedge core_clk) disable iff (srst)
		psel && !penable && paddr == spd_pkg::ADDR_CLK_TEST |=>
			prdata == {24'h0, $past(clock_test_select), 7'h0};
	endproperty
	a_rd_test: assert property (p_rd_test)
		else $error("clock test read wrong");

	property p_rd_mode;
		@(posedge core_clk) disable iff (srst)
		psel && !penable && paddr == spd_pkg::ADDR_MODE |=>
			prdata == {31'h0, $past(second_mode)};
	endproperty
	a_rd_mode: assert property (p_rd_mode)
		else $error("mode read wrong");

	property p_rd_status;
		@(posedge core_clk) disable iff (srst)
		psel && !penable && paddr == spd_pkg::ADDR_STATUS |=>
			prdata == {29'h0, $past(converter_clk),
			$past(sif.timing_sync), $past(sync_level)};
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status read wrong");

	property p_rd_unmapped;
		@(posedge core_clk) disable iff (srst)
		psel && !penable && !addr_known(paddr) |=> prdata == 32'h0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");

	// A disagreeing late stage is a glitch and must not pass
	property p_sync_hold;
		@(posedge core_clk) disable iff (srst)
		sync_pipe[1] != sync_pipe[2] |=> $stable(sync_level);
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("sync level moved on disagreement");

	property p_sync_take;
		@(posedge core_clk) disable iff (srst)
		sync_pipe[1] == sync_pipe[2] |=> sync_level == $past(sync_pipe[2]);
	endproperty
	a_sync_take: assert property (p_sync_take)
		else $error("agreed sync level not taken");

	property p_conv_one;
		@(posedge core_clk) disable iff (srst)
		converter_clk |=> !converter_clk;
	endproperty
	a_conv_one: assert property (p_conv_one)
		else $error("converter clock high too long");
endmodule // spd_timing_front

// *** bench/spd_far_side.sv ***
`timescale 1ns/1ps
module spd_far_side (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// Bench command
	input  wire logic       sync_cmd,
	// Pins toward the block
	output logic            video_sample_sync_input,
	output logic            video_sample_clk,
	output logic            reset_sample_clk,
	output logic      [3:0] sample_nibble
);
	// Clocks toggle and the nibble counts each edge, so a stale copy is always visible; the sync pin follows sync_cmd
	always_ff @(posedge core_clk) begin
		if (srst) begin
			video_sample_sync_input <= 1'b0;
			video_sample_clk        <= 1'b0;
			reset_sample_clk        <= 1'b1;
			sample_nibble           <= 4'h0;
		end else begin
			video_sample_sync_input <= sync_cmd;
			video_sample_clk        <= ~video_sample_clk;
			reset_sample_clk        <= ~reset_sample_clk;
			sample_nibble           <= sample_nibble + 4'h1;
		end
	end
endmodule // spd_far_side

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic [7:0]  paddr    = 8'h00;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic        sync_cmd = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, prev;
	logic        vs_pin, vclk, rclk, timing_sync, converter_clk;
	logic [3:0]  sample_nibble, nibble_output;
	int          mismatches = 0, total_checks = 0, cycles = 0, k, n;
	// Cases as {enable, polarity, delay}
	logic [4:0]  cases [4] = '{5'h0d, 5'h18, 5'h17, 5'h1a};

	spd_far_side far (.core_clk(core_clk), .srst(srst), .sync_cmd(sync_cmd),
		.video_sample_sync_input(vs_pin), .video_sample_clk(vclk),
		.reset_sample_clk(rclk), .sample_nibble(sample_nibble));
	spd_timing_front dut (.core_clk(core_clk), .srst(srst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.video_sample_sync_input(vs_pin), .video_sample_clk(vclk),
		.reset_sample_clk(rclk), .timing_sync(timing_sync),
		.converter_clk(converter_clk), .sample_nibble(sample_nibble),
		.nibble_output(nibble_output));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always #5 core_clk = ~core_clk;

	// Hang guard, far above the 150 or so cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end

	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		apb(1'b0, spd_pkg::ADDR_SYNC_SETUP, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, spd_pkg::ADDR_CLK_TEST, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, err}, 32'h1);
		repeat (4) begin
			@(posedge core_clk); #1;
			check(nibble_output, 4'(sample_nibble - 4'h1));
		end
		apb(1'b1, spd_pkg::ADDR_CLK_TEST, 32'h80);
		apb(1'b0, spd_pkg::ADDR_CLK_TEST, 32'h0);
		check(rd, 32'h80);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, spd_pkg::ADDR_SYNC_SETUP,
				{27'h0, cases[i][3], cases[i][2:0], cases[i][4]});
			sync_cmd <= ~cases[i][3];
			for (k = 1; k <= 10; k++) begin
				@(posedge core_clk); #1;
				if (k > 3)
					check(timing_sync, !cases[i][3] && !cases[i][4]);
			end
			sync_cmd <= cases[i][3];
			n = 0;
			for (k = 1; k <= 16 && n == 0; k++) begin
				@(posedge core_clk); #1;
				if (timing_sync === 1'b1)
					n = k;
			end
			// Far-side flop, three stages and filter flop, then output flop
			check(n, cases[i][4] ? 6 + cases[i][2:0] : 6);
			if (cases[i][4])
				check(nibble_output[3], 1'b1);
			@(posedge core_clk); #1;
			check(timing_sync, !cases[i][4]);
		end
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, spd_pkg::ADDR_MODE, 32'(m));
			apb(1'b0, spd_pkg::ADDR_MODE, 32'h0);
			check(rd, 32'(m));
			@(posedge core_clk); #1;
			prev = converter_clk;
			n = 0;
			repeat (12) begin
				@(posedge core_clk); #1;
				n += converter_clk;
				check(nibble_output[1], prev);
				check(nibble_output[2], !vclk);
				check(nibble_output[0], !rclk);
				prev = converter_clk;
			end
			check(n, m ? 4 : 6);
		end
		summarize();
	end
endmodule // testbench
